// ===== design/cpu_special_registers_defines.svh
// Offsets, flag positions, reset values and timing counts of the special registers.
`ifndef CPU_SPECIAL_REGISTERS_DEFINES_SVH
`define CPU_SPECIAL_REGISTERS_DEFINES_SVH

// Special register offsets within data memory sector 0.
`define OFS_PORT0        8'h00
`define OFS_PTR0         8'h01
`define OFS_PORT1        8'h02
`define OFS_PTR1_LOW     8'h03
`define OFS_PTR1_SECTOR  8'h04
`define OFS_PORT2        8'h05
`define OFS_PTR2_LOW     8'h06
`define OFS_PTR2_SECTOR  8'h07
`define OFS_PC_LOW       8'h08
`define OFS_TBL_LOW      8'h09
`define OFS_TBL_HIGH_PTR 8'h0A
`define OFS_TBL_DATA_HI  8'h0B
`define OFS_STATUS       8'h0C
`define OFS_BANK         8'h0D
// First offset above the special register area.
`define OFS_SFR_LIMIT    8'h10

// Data memory address layout.
`define ADDR_W           10
`define SECTOR_W         2

// Flag positions in the status register.
`define ST_C             0
`define ST_AC            1
`define ST_Z             2
`define ST_OV            3
`define ST_PDF           4
`define ST_TO            5
`define ST_CZ            6
`define ST_SC            7

// Bits that a data write may change in the status register.
`define STATUS_WR_MASK   8'hCF

// Reset values.
`define STATUS_RST       8'h00
`define BANK_RST         8'h00
`define PTR_RST          8'h00

// Dummy cycles inserted after a program counter low byte write.
`define PC_DUMMY_CYCLES  1

`endif

// ===== design/cpu_sfr_pkg.sv
// Types shared by the special register block and its flag unit.
package cpu_sfr_pkg;

  // Operation class presented by the execution pipeline.
  typedef enum logic [2:0] {
    ALU_ADD,
    ALU_ADC,
    ALU_SUB,
    ALU_SBC,
    ALU_LOGIC,
    ALU_RLC,
    ALU_RRC
  } alu_op_t;

  // Where a resolved data access lands.
  typedef enum logic [1:0] {
    TGT_ZERO,
    TGT_REG,
    TGT_MEM
  } target_t;

endpackage

// ===== design/flag_alu.sv
// Arithmetic core that produces a result and the next status byte.
`timescale 1ns/1ns
`include "cpu_special_registers_defines.svh"

module flag_alu (
  input  cpu_sfr_pkg::alu_op_t op,
  input  logic [7:0]           a,
  input  logic [7:0]           b,
  input  logic [7:0]           status_in,
  output logic [7:0]           result,
  output logic [7:0]           status_out
);
  import cpu_sfr_pkg::*;

  // Differences add the inverted operand, so carry out means no borrow.
  wire       sub_op = (op == ALU_SUB) || (op == ALU_SBC);
  wire [7:0] b_eff  = sub_op ? ~b : b;
  wire       cin    = (op == ALU_ADD) ? 1'b0 : (op == ALU_SUB) ? 1'b1 : status_in[`ST_C];
  // Partial sums give nibble carry, carry into bit 7 and carry out.
  wire [4:0] sum4   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire [7:0] sum7   = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
  wire [8:0] sum8   = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
  wire       ov     = sum7[7] ^ sum8[8];
  wire       zero   = (sum8[7:0] == 8'h00);

  // Each class touches only its own flags; system flags always pass.
  always_comb begin
    result     = a;
    status_out = status_in;
    case (op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        result = sum8[7:0];
        status_out[`ST_C]  = sum8[8];
        status_out[`ST_AC] = sum4[4];
        status_out[`ST_Z]  = zero;
        status_out[`ST_OV] = ov;
        status_out[`ST_SC] = ov ^ sum8[7];
        if (op == ALU_SUB) begin
          status_out[`ST_CZ] = zero;
        end else if (op == ALU_SBC) begin
          status_out[`ST_CZ] = status_in[`ST_CZ] & zero;
        end
      end
      ALU_LOGIC: begin
        // Logical results arrive ready-made on b; only zero is judged.
        result = b;
        status_out[`ST_Z] = (b == 8'h00);
      end
      ALU_RLC: begin
        result = {a[6:0], status_in[`ST_C]};
        status_out[`ST_C] = a[7];
      end
      ALU_RRC: begin
        result = {status_in[`ST_C], a[7:1]};
        status_out[`ST_C] = a[0];
      end
      default: begin
        result     = a;
        status_out = status_in;
      end
    endcase
  end

endmodule

// ===== design/cpu_special_registers.sv
// Special registers of the core: indirect ports, pointers, bank, table and status.
`timescale 1ns/1ns
`include "cpu_special_registers_defines.svh"
// Overview of operation
// - Indirect port locations read zero, ignore writes.
// - Port accesses redirect to their pointer's location.
// - Port zero with pointer zero: sector 0.
// - Ports one, two: sector byte plus low.
// - Five pointers are ordinary read/write registers.
// - Extended direct addresses choose sector by upper bits.
// - Bank bit picks code bank; resets 0.
// - Low PC write jumps in page, dummy cycle.
// - Table read: high byte kept, low delivered.
// - Data writes never change timeout/halt flags.
// - Timeout flag: cleared by clear/halt, set timeout.
// - Halt flag: cleared by clear, set halt.
// - Carry from add, no-borrow, or rotate.
// - Nibble carry from low nibble add/sub.
// - Zero flag follows zero result.
// - Wrap flag: carry in/out msb differ.
// - Signed compare is wrap xor msb.
// - Chained zero follows sub, ands for sbc.
// - Status is never saved automatically.
// - Timeout and halt flags reset to zero.

module cpu_special_registers (
  input  logic                 clk,
  input  logic                 rstn,
  input  logic                 req_valid,
  input  logic                 req_write,
  input  logic                 req_ext,
  input  logic [9:0]           req_addr,
  input  logic [7:0]           req_wdata,
  output logic                 rd_valid,
  output logic [7:0]           rd_data,
  output logic                 mem_valid,
  output logic                 mem_write,
  output logic [9:0]           mem_addr,
  output logic [7:0]           mem_wdata,
  input  logic [7:0]           mem_rdata,
  input  logic [7:0]           pc_low_now,
  output logic                 pc_load,
  output logic [7:0]           pc_load_value,
  output logic                 pc_dummy,
  output logic                 code_bank,
  input  logic                 tbl_read,
  output logic                 prog_rd,
  output logic [15:0]          prog_addr,
  input  logic [15:0]          prog_word,
  output logic                 tbl_low_valid,
  output logic [7:0]           tbl_low_data,
  input  logic                 alu_valid,
  input  cpu_sfr_pkg::alu_op_t alu_op,
  input  logic [7:0]           alu_a,
  input  logic [7:0]           alu_b,
  output logic                 alu_done,
  output logic [7:0]           alu_result,
  input  logic                 wdt_clear_ins,
  input  logic                 halt_ins,
  input  logic                 wdt_timeout,
  output logic [7:0]           status
);
  import cpu_sfr_pkg::*;

  // Sector 0 address of a special register offset.
  function automatic logic [9:0] sfr_addr(input logic [7:0] ofs);
    sfr_addr = {2'b00, ofs};
  endfunction

  // True when an address is one of the three indirect port locations.
  function automatic logic is_port(input logic [9:0] a);
    is_port = (a == sfr_addr(`OFS_PORT0)) || (a == sfr_addr(`OFS_PORT1))
           || (a == sfr_addr(`OFS_PORT2));
  endfunction

  // Pointer registers, held as flip-flops inside the special register area.
  logic [7:0]  ptr0_q;            // Pointer zero.
  logic [7:0]  ptr1_low_q;        // Pointer one, offset in sector.
  logic [7:0]  ptr1_sector_q;     // Pointer one, sector select.
  logic [7:0]  ptr2_low_q;        // Pointer two, offset in sector.
  logic [7:0]  ptr2_sector_q;     // Pointer two, sector select.
  logic [7:0]  tbl_low_q;         // Table pointer low byte.
  logic [7:0]  tbl_high_ptr_q;    // Table pointer high byte.
  logic [7:0]  tbl_data_hi_q;     // High byte of the last table word.
  logic [7:0]  status_d;          // Next status byte.
  logic [7:0]  reg_rdata;         // Read value of the addressed register.
  logic        rd_pend_q;         // A read is in its memory cycle.
  target_t     rd_tgt_q;          // Where that read landed.
  logic [7:0]  rd_reg_q;          // Register value captured for that read.
  logic [7:0]  alu_res_w;         // Result from the flag unit.
  logic [7:0]  alu_st_w;          // Status from the flag unit.

  // Direct address: short instructions only see sector 0.
  // extended sector select
  wire [9:0] direct_addr = req_ext ? req_addr : {2'b00, req_addr[7:0]};
  // Indirect ports swap the direct address for their pointer's target.
  // pointer zero sector 0
  wire [9:0] ptr0_target = {2'b00, ptr0_q};
  wire [9:0] ptr1_target = {ptr1_sector_q[`SECTOR_W-1:0], ptr1_low_q};
  wire [9:0] ptr2_target = {ptr2_sector_q[`SECTOR_W-1:0], ptr2_low_q};
  wire       via_port0   = (direct_addr == sfr_addr(`OFS_PORT0));
  wire       via_port1   = (direct_addr == sfr_addr(`OFS_PORT1));
  wire       via_port2   = (direct_addr == sfr_addr(`OFS_PORT2));
  wire [9:0] eff_addr    = via_port0 ? ptr0_target :
                           via_port1 ? ptr1_target :
                           via_port2 ? ptr2_target : direct_addr;
  // A pointer aimed back at a port finds no storage there.
  // port location is empty
  wire       hit_port    = is_port(eff_addr);
  wire       hit_sfr     = (eff_addr[9:8] == 2'b00) && (eff_addr[7:0] < `OFS_SFR_LIMIT);
  wire target_t tgt      = hit_port ? TGT_ZERO : hit_sfr ? TGT_REG : TGT_MEM;
  wire [7:0] ofs         = eff_addr[7:0];
  // Register writes and reads, one strobe per access kind.
  wire       reg_wr      = req_valid && req_write && (tgt == TGT_REG);
  wire       rd_req      = req_valid && !req_write;
  wire       mem_req     = req_valid && (tgt == TGT_MEM);
  wire       wr_status   = reg_wr && (ofs == `OFS_STATUS);
  wire       wr_pc_low   = reg_wr && (ofs == `OFS_PC_LOW);
  // Flag unit works on the current status.
  flag_alu u_flag_alu (
    .op         (alu_op),
    .a          (alu_a),
    .b          (alu_b),
    .status_in  (status),
    .result     (alu_res_w),
    .status_out (alu_st_w)
  );

  // Read mux of the special register area; unused offsets read zero.
  always_comb begin
    case (ofs)
      `OFS_PTR0:         reg_rdata = ptr0_q;
      `OFS_PTR1_LOW:     reg_rdata = ptr1_low_q;
      `OFS_PTR1_SECTOR:  reg_rdata = ptr1_sector_q;
      `OFS_PTR2_LOW:     reg_rdata = ptr2_low_q;
      `OFS_PTR2_SECTOR:  reg_rdata = ptr2_sector_q;
      `OFS_PC_LOW:       reg_rdata = pc_low_now;
      `OFS_TBL_LOW:      reg_rdata = tbl_low_q;
      `OFS_TBL_HIGH_PTR: reg_rdata = tbl_high_ptr_q;
      `OFS_TBL_DATA_HI:  reg_rdata = tbl_data_hi_q;
      `OFS_STATUS:       reg_rdata = status;
      `OFS_BANK:         reg_rdata = {7'h00, code_bank};
      default:           reg_rdata = 8'h00;
    endcase
  end

  // Next status: arithmetic first, then a data write, then system events.
  // never pushed; software saves it
  always_comb begin
    status_d = status;
    if (alu_valid) begin
      status_d = alu_st_w;
    end
    if (wr_status) begin
      status_d = (req_wdata & `STATUS_WR_MASK) | (status_d & ~`STATUS_WR_MASK);
    end
    if (wdt_timeout) begin
      status_d[`ST_TO] = 1'b1;
    end else if (wdt_clear_ins || halt_ins) begin
      status_d[`ST_TO] = 1'b0;
    end
    if (halt_ins) begin
      status_d[`ST_PDF] = 1'b1;
    end else if (wdt_clear_ins) begin
      status_d[`ST_PDF] = 1'b0;
    end
  end

  // Status flags; all of them start from a known zero.
  // power-on flag values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= `STATUS_RST;
    end else begin
      status <= status_d;
    end
  end
  // Pointers behave like plain byte registers; only a data write changes them.
  // pointers are writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr0_q        <= `PTR_RST;
      ptr1_low_q    <= `PTR_RST;
      ptr1_sector_q <= `PTR_RST;
      ptr2_low_q    <= `PTR_RST;
      ptr2_sector_q <= `PTR_RST;
    end else if (reg_wr) begin
      if (ofs == `OFS_PTR0)        ptr0_q        <= req_wdata;
      if (ofs == `OFS_PTR1_LOW)    ptr1_low_q    <= req_wdata;
      if (ofs == `OFS_PTR1_SECTOR) ptr1_sector_q <= req_wdata;
      if (ofs == `OFS_PTR2_LOW)    ptr2_low_q    <= req_wdata;
      if (ofs == `OFS_PTR2_SECTOR) ptr2_sector_q <= req_wdata;
    end
  end
  // Code bank select; only bit 0 is stored.
  // bank bit register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_bank <= 1'(`BANK_RST);
    end else if (reg_wr && (ofs == `OFS_BANK)) begin
      code_bank <= req_wdata[0];
    end
  end
  // Table pointers are writable; the high data byte is loaded only by a read.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tbl_low_q      <= `PTR_RST;
      tbl_high_ptr_q <= `PTR_RST;
    end else if (reg_wr) begin
      if (ofs == `OFS_TBL_LOW)      tbl_low_q      <= req_wdata;
      if (ofs == `OFS_TBL_HIGH_PTR) tbl_high_ptr_q <= req_wdata;
    end
  end
  // Table fetch: address out one cycle, word split on the next edge.
  // table word split
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_rd       <= 1'b0;
      prog_addr     <= 16'h0000;
      tbl_low_valid <= 1'b0;
      tbl_low_data  <= 8'h00;
      tbl_data_hi_q <= 8'h00;
    end else begin
      prog_rd       <= tbl_read;
      prog_addr     <= tbl_read ? {tbl_high_ptr_q, tbl_low_q} : prog_addr;
      tbl_low_valid <= prog_rd;
      if (prog_rd) begin
        tbl_low_data  <= prog_word[7:0];
        tbl_data_hi_q <= prog_word[15:8];
      end
    end
  end
  // Program counter low write: jump pulse, then the dummy cycle.
  // in-page jump with dummy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_load       <= 1'b0;
      pc_load_value <= 8'h00;
      pc_dummy      <= 1'b0;
    end else begin
      pc_load       <= wr_pc_low;
      pc_load_value <= wr_pc_low ? req_wdata : pc_load_value;
      pc_dummy      <= pc_load;
    end
  end
  // Data memory port; port-location and register accesses never reach it.
  // writes to ports dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= 10'h000;
      mem_wdata <= 8'h00;
    end else begin
      mem_valid <= mem_req;
      mem_write <= mem_req && req_write;
      mem_addr  <= mem_req ? eff_addr : mem_addr;
      mem_wdata <= mem_req ? req_wdata : mem_wdata;
    end
  end
  // Reads take two edges so memory and register reads line up alike.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend_q <= 1'b0;
      rd_tgt_q  <= TGT_ZERO;
      rd_reg_q  <= 8'h00;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      rd_pend_q <= rd_req;
      rd_tgt_q  <= tgt;
      rd_reg_q  <= reg_rdata;
      rd_valid  <= rd_pend_q;
      rd_data   <= (rd_tgt_q == TGT_MEM) ? mem_rdata :
                   (rd_tgt_q == TGT_REG) ? rd_reg_q : 8'h00;
    end
  end
  // Result of the flag unit, held for the pipeline.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alu_done   <= 1'b0;
      alu_result <= 8'h00;
    end else begin
      alu_done   <= alu_valid;
      alu_result <= alu_valid ? alu_res_w : alu_result;
    end
  end

  // Checks of the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire       quiet_sys = !wdt_timeout && !wdt_clear_ins && !halt_ins;
  wire       arith     = alu_valid && (alu_op inside {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC});
  wire [8:0] add_chk   = {1'b0, alu_a} + {1'b0, alu_b};
  a_port_read_zero: assert property (rd_req && tgt == TGT_ZERO |-> ##2 rd_valid
    && rd_data == 8'h00) else $error("Port location read did not return zero.");
  a_port_write_drop: assert property (req_valid && tgt == TGT_ZERO |=> !mem_valid)
    else $error("Port location access reached data memory.");
  a_redirect_addr: assert property (mem_req && via_port1 |=>
    mem_addr == $past(ptr1_target)) else $error("Port one access off its pointer target.");
  a_port0_sector: assert property (req_valid && via_port0 |=>
    !mem_valid || mem_addr[9:8] == 2'b00) else $error("Pointer zero left sector zero.");
  a_ext_direct: assert property (mem_req && req_ext && !is_port(direct_addr) |=>
    mem_addr == $past(req_addr)) else $error("Extended address not used as given.");
  a_bank_read_upper: assert property (rd_req && tgt == TGT_REG && ofs == `OFS_BANK |->
    ##2 rd_data[7:1] == 7'h00) else $error("Bank register upper bits not zero.");
  a_pc_jump_dummy: assert property (wr_pc_low |=> pc_load
    && pc_load_value == $past(req_wdata) ##1 pc_dummy) else $error("Jump pulse wrong.");
  a_table_split: assert property (tbl_read |=> prog_rd ##1 tbl_low_valid
    && tbl_low_data == $past(prog_word[7:0]) && tbl_data_hi_q == $past(prog_word[15:8]))
    else $error("Table word not split into high and low bytes.");
  a_status_write_sys: assert property (wr_status && quiet_sys |=>
    status[5:4] == $past(status[5:4])) else $error("Data write altered a system flag.");
  a_timeout_set: assert property (wdt_timeout |=> status[`ST_TO])
    else $error("Timeout did not set its flag.");
  a_halt_flags: assert property (halt_ins && !wdt_timeout |=>
    status[`ST_PDF] && !status[`ST_TO]) else $error("Halt flag update wrong.");
  a_add_carry: assert property (alu_valid && alu_op == ALU_ADD && !wr_status |=>
    status[`ST_C] == $past(add_chk[8])) else $error("Addition carry wrong.");
  a_sc_from_ov: assert property (arith && !wr_status |=>
    status[`ST_SC] == (status[`ST_OV] ^ alu_result[7])) else $error("Signed compare wrong.");
  a_cz_chain: assert property (alu_valid && alu_op == ALU_SBC && !wr_status |=>
    status[`ST_CZ] == ($past(status[`ST_CZ]) && status[`ST_Z])) else $error("Chain flag wrong.");
  c_port1_sector: cover property (mem_req && via_port1 && ptr1_sector_q != 8'h00);
  c_table_read: cover property (tbl_read ##2 tbl_low_valid);
  c_halt_then_clear: cover property (halt_ins ##[1:20] wdt_clear_ins);

endmodule

// ===== dv/mem_model.sv
// Behavioural data memory and program memory facing the special register block.
`timescale 1ns/1ns

module mem_model (
  input  wire logic        clk,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic [9:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  input  wire logic        prog_rd,
  input  wire logic [15:0] prog_addr,
  output logic      [15:0] prog_word
);
  logic [7:0]  mem [1024];  // Data memory, seeded with an address pattern.
  logic [7:0]  rd_last;     // Last byte shown, inverted while idle.
  logic [15:0] pw_last;     // Last word shown, inverted while idle.

  // Known contents let the bench predict reads of untouched locations.
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h3C;
    rd_last = 8'h00;
    pw_last = 16'h0000;
  end

  // Idle buses toggle so that stale data never passes for a fresh answer.
  assign mem_rdata = mem_valid ? mem[mem_addr] : ~rd_last;
  assign prog_word = prog_rd ? {prog_addr[7:0] ^ 8'h96, prog_addr[15:8] ^ 8'h69} : ~pw_last;

  // Writes land at the edge that samples the access.
  always @(posedge clk) begin
    if (mem_valid && mem_write) mem[mem_addr] <= mem_wdata;
    rd_last <= mem_rdata;
    pw_last <= prog_word;
  end
endmodule

// ===== dv/cpu_special_registers_tb_top.sv
// Self-checking bench for the special register block.
`timescale 1ns/1ns

module cpu_special_registers_tb_top;
  import cpu_sfr_pkg::*;

  logic        clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_ext = 1'b0;
  logic        tbl_read = 1'b0, alu_valid = 1'b0, wdt_clear_ins = 1'b0, halt_ins = 1'b0;
  logic        wdt_timeout = 1'b0;
  logic [9:0]  req_addr = 10'h000;
  logic [7:0]  req_wdata = 8'h00, pc_low_now = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  alu_op_t     alu_op = ALU_ADD;
  logic        rd_valid, mem_valid, mem_write, pc_load, pc_dummy, code_bank;
  logic        prog_rd, tbl_low_valid, alu_done;
  logic [9:0]  mem_addr;
  logic [7:0]  rd_data, mem_wdata, mem_rdata, pc_load_value, tbl_low_data, alu_result, status;
  logic [15:0] prog_addr, prog_word;
  logic [7:0]  st, d, e, p, v;   // Status shadow and scratch values.
  logic [7:0]  sh [1024];        // Shadow of the data memory contents.
  logic [7:0]  rdq [$];          // Expected read data, oldest first.
  logic [18:0] mq [$];           // Expected memory accesses {write, addr, data}.
  logic [15:0] aq [$];           // Expected {result, status} of ALU operations.
  int          err_count = 0, comparisons = 0;

  cpu_special_registers cpu_special_registers_i (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write), .req_ext(req_ext),
    .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .pc_low_now(pc_low_now), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .pc_dummy(pc_dummy), .code_bank(code_bank),
    .tbl_read(tbl_read), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_word(prog_word),
    .tbl_low_valid(tbl_low_valid), .tbl_low_data(tbl_low_data), .alu_valid(alu_valid),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_done(alu_done),
    .alu_result(alu_result), .wdt_clear_ins(wdt_clear_ins), .halt_ins(halt_ins),
    .wdt_timeout(wdt_timeout), .status(status));

  mem_model mem_model_i (
    .clk(clk), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_word(prog_word));

  // Free-running 250 MHz system clock.
  always #2 clk = ~clk;

  task automatic cmp(input string n, input logic [31:0] ex, input logic [31:0] seen);
    comparisons++;
    if (seen !== ex) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", n, ex, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One access per call; the idle cycle after it keeps strobes from colliding.
  task automatic acc(input logic w, input logic x, input logic [9:0] ad, input logic [7:0] dt,
                     input logic [7:0] ex, input logic m, input logic [9:0] ma);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_ext   <= x;
    req_addr  <= ad;
    req_wdata <= dt;
    if (m) mq.push_back({w, ma, w ? dt : 8'h00});
    if (m && w) sh[ma] = dt;
    if (!w) rdq.push_back(m ? sh[ma] : ex);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  // Reference arithmetic: subtraction adds the inverted operand plus carry in.
  task automatic alu(input alu_op_t o, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] c7, bb, r, ns;
    logic       ci, ov;
    bb = (o == ALU_SUB || o == ALU_SBC) ? ~b : b;
    ci = (o == ALU_SUB) ? 1'b1 : (o == ALU_ADC || o == ALU_SBC) ? st[0] : 1'b0;
    s = a + bb + ci;
    h = a[3:0] + bb[3:0] + ci;
    c7 = a[6:0] + bb[6:0] + ci;
    r = s[7:0];
    ns = st;
    ov = c7[7] ^ s[8];
    case (o)
      ALU_LOGIC: begin
        r = b;
        ns[2] = (b == 8'h00);
      end
      ALU_RLC: begin
        r = {a[6:0], st[0]};
        ns[0] = a[7];
      end
      ALU_RRC: begin
        r = {st[0], a[7:1]};
        ns[0] = a[0];
      end
      default: begin
        ns[3:0] = {ov, r == 8'h00, h[4], s[8]};
        ns[7] = ov ^ r[7];
        if (o == ALU_SUB) ns[6] = ns[2];
        if (o == ALU_SBC) ns[6] = st[6] & ns[2];
      end
    endcase
    st = ns;
    aq.push_back({r, ns});
    @(posedge clk);
    alu_valid <= 1'b1;
    alu_op    <= o;
    alu_a     <= a;
    alu_b     <= b;
    @(posedge clk);
    alu_valid <= 1'b0;
  endtask

  // Pulses the system events and checks the status byte once they land.
  task automatic ev(input logic t, input logic h, input logic c);
    @(posedge clk);
    wdt_timeout   <= t;
    halt_ins      <= h;
    wdt_clear_ins <= c;
    if (c || h) st[5] = 1'b0;
    if (t) st[5] = 1'b1;
    if (c) st[4] = 1'b0;
    if (h) st[4] = 1'b1;
    @(posedge clk);
    wdt_timeout   <= 1'b0;
    halt_ins      <= 1'b0;
    wdt_clear_ins <= 1'b0;
    #1;
    cmp("status", st, status);
  endtask

  // Results are matched in arrival order against the oldest expectation.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (rdq.size() == 0) cmp("rd_extra", 0, 1);
      else cmp("rd_data", rdq.pop_front(), rd_data);
    end
    if (mem_valid === 1'b1) begin
      if (mq.size() == 0) cmp("mem_extra", 0, 1);
      else cmp("mem", mq.pop_front(), {mem_write, mem_addr, mem_write ? mem_wdata : 8'h00});
    end
    if (alu_done === 1'b1) begin
      if (aq.size() == 0) cmp("alu_extra", 0, 1);
      else cmp("alu", aq.pop_front(), {alu_result, status});
    end
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    cmp("timeout", 0, 1);
    final_report;
  end

  initial begin
    for (int i = 0; i < 1024; i++) sh[i] = 8'(i) ^ 8'h3C;
    st = 8'h00;
    void'($urandom(32'hB6CF3552));
    pc_low_now <= 8'($urandom);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    cmp("status", 8'h00, status);
    cmp("code_bank", 0, code_bank);
    acc(1, 0, 10'h00D, 8'hFF, 0, 0, 0);
    acc(0, 0, 10'h00D, 0, 8'h01, 0, 0);
    cmp("code_bank", 1, code_bank);
    acc(1, 0, 10'h00E, 8'hAA, 0, 0, 0);
    acc(0, 0, 10'h00E, 0, 8'h00, 0, 0);
    acc(0, 0, 10'h008, 0, pc_low_now, 0, 0);
    d = 8'($urandom);
    acc(1, 0, 10'h008, d, 0, 0, 0);
    #1;
    cmp("pc_load", {1'b1, d}, {pc_load, pc_load_value});
    @(posedge clk);
    #1;
    cmp("pc_dummy", 2'b10, {pc_dummy, pc_load});
    $display("test bank_pc done");
    e = 8'($urandom);
    acc(1, 0, 10'h009, d, 0, 0, 0);
    acc(1, 0, 10'h00A, e, 0, 0, 0);
    @(posedge clk);
    tbl_read <= 1'b1;
    @(posedge clk);
    tbl_read <= 1'b0;
    #1;
    cmp("prog", {1'b1, e, d}, {prog_rd, prog_addr});
    @(posedge clk);
    #1;
    cmp("tbl_low", {1'b1, e ^ 8'h69}, {tbl_low_valid, tbl_low_data});
    acc(1, 0, 10'h00B, 8'h5A, 0, 0, 0);
    acc(0, 0, 10'h00B, 0, d ^ 8'h96, 0, 0);
    $display("test table done");
    // Pointer aimed at another port location must be refused both ways.
    acc(1, 0, 10'h001, 8'h05, 0, 0, 0);
    acc(0, 0, 10'h000, 0, 8'h00, 0, 0);
    acc(1, 0, 10'h000, 8'h77, 0, 0, 0);
    p = 8'h40 | 8'($urandom % 64);
    acc(1, 0, 10'h001, p, 0, 0, 0);
    acc(1, 0, 10'h000, d, 0, 1, {2'b00, p});
    acc(0, 0, {2'b00, p}, 0, 0, 1, {2'b00, p});
    acc(0, 0, 10'h001, 0, p, 0, 0);
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      p = 8'h10 | 8'($urandom);
      d = 8'($urandom);
      acc(1, 0, 10'h004 + 10'(3 * k), v, 0, 0, 0);
      acc(1, 0, 10'h003 + 10'(3 * k), p, 0, 0, 0);
      acc(0, 0, 10'h004 + 10'(3 * k), 0, v, 0, 0);
      acc(0, 0, 10'h003 + 10'(3 * k), 0, p, 0, 0);
      acc(1, 0, 10'h002 + 10'(3 * k), d, 0, 1, {v[1:0], p});
      acc(0, 0, 10'h002 + 10'(3 * k), 0, 0, 1, {v[1:0], p});
      acc(0, 1, {v[1:0], p}, 0, 0, 1, {v[1:0], p});
    end
    $display("test indirect done");
    acc(1, 0, 10'h00C, 8'hFF, 0, 0, 0);
    st = 8'hCF;
    acc(0, 0, 10'h00C, 0, st, 0, 0);
    ev(1, 0, 0);
    ev(0, 1, 0);
    ev(1, 1, 0);
    acc(1, 0, 10'h00C, 8'h00, 0, 0, 0);
    st = st & 8'h30;
    acc(0, 0, 10'h00C, 0, st, 0, 0);
    ev(0, 0, 1);
    $display("test status done");
    for (int i = 0; i < 35; i++) begin
      d = (i < 7) ? 8'h00 : 8'($urandom);
      e = (i < 7) ? 8'h00 : 8'($urandom);
      alu(alu_op_t'(i % 7), d, e);
    end
    $display("test alu done");
    for (int i = 0; i < 10 && (rdq.size() + mq.size() + aq.size()) != 0; i++) @(posedge clk);
    cmp("queues", 0, rdq.size() + mq.size() + aq.size());
    final_report;
  end
endmodule
